// ===== hw/hlrt_top.v
// event log, change log and generator run-time counter
`timescale 1ns/1ps
`include "hlrt_defs.vh"
module hlrt_top #(
   parameter [63:0] MIN_CYCLES = `HLRT_MINUTE_CYCLES,
   parameter        EVT_DEPTH  = `HLRT_EVT_DEPTH,
   parameter        EVT_PW     = `HLRT_EVT_PW,
   parameter        CHG_DEPTH  = `HLRT_CHG_DEPTH,
   parameter        CHG_PW     = `HLRT_CHG_PW
) (
   input  wire                     mclk_in,
   input  wire                     arst_n_in,
   input  wire [`HLRT_TS_W-1:0]    timestamp_in,
   input  wire                     evt_valid_in,
   input  wire [`HLRT_CODE_W-1:0]  evt_code_in,
   input  wire [EVT_PW-1:0]        evt_rd_idx_in,
   output wire [`HLRT_TS_W+`HLRT_CODE_W-1:0] evt_rd_data_out,
   output wire                     evt_rd_valid_out,
   output wire [EVT_PW-1:0]        evt_count_out,
   input  wire                     chg_valid_in,
   input  wire [`HLRT_CODE_W-1:0]  chg_id_in,
   input  wire [`HLRT_VAL_W-1:0]   chg_old_in,
   input  wire [`HLRT_VAL_W-1:0]   chg_new_in,
   input  wire                     chg_clear_in,
   input  wire [CHG_PW-1:0]        chg_rd_idx_in,
   output wire [`HLRT_CODE_W+`HLRT_TS_W+2*`HLRT_VAL_W-1:0] chg_rd_data_out,
   output wire                     chg_rd_valid_out,
   output wire [CHG_PW-1:0]        chg_count_out,
   input  wire                     src_is_emerg_in,
   input  wire                     rt_enable_in,
   input  wire [`HLRT_VAL_W-1:0]   emerg_volt_in,
   input  wire [`HLRT_VAL_W-1:0]   emerg_nom_in,
   input  wire                     rt_reset_in,
   input  wire                     nv_load_in,
   input  wire [15:0]              nv_load_hours_in,
   input  wire [5:0]               nv_load_minutes_in,
   output reg  [15:0]              rt_hours_out,
   output reg  [5:0]               rt_minutes_out,
   output reg                      rt_running_out,
   output reg                      min_tick_out,
   output reg                      nv_save_out,
   output reg  [15:0]              nv_hours_out,
   output reg  [5:0]               nv_minutes_out
);
   localparam EVT_W = `HLRT_TS_W + `HLRT_CODE_W;
   localparam CHG_W = `HLRT_CODE_W + `HLRT_TS_W + 2 * `HLRT_VAL_W;

   wire [EVT_W-1:0] evt_entry;
   wire [CHG_W-1:0] chg_entry;

   reg  [31:0]      div_reg;
   reg  [31:0]      div_next;
   reg              tick_next;
   reg              above_half;
   reg              count_ok;
   reg  [15:0]      hours_next;
   reg  [5:0]       minutes_next;
   reg  [3:0]       save_cnt_reg;
   reg  [3:0]       save_cnt_next;
   reg              save_next;

   // one minute on, minutes carry into hours
   function [21:0] rt_advance;
      input [15:0] hours;
      input [5:0]  minutes;
      begin
         if (minutes != `HLRT_MIN_LAST)
            rt_advance = {hours, minutes + 6'h01};
         else if (hours == `HLRT_HOURS_LAST)
            rt_advance = {`HLRT_HOURS_RST, `HLRT_MIN_RST};
         else
            rt_advance = {hours + 16'h0001, `HLRT_MIN_RST};
      end
   endfunction

   // restored minutes past the hour restart it
   function [5:0] min_clamp;
      input [5:0] minutes;
      begin
         if (minutes > `HLRT_MIN_LAST)
            min_clamp = `HLRT_MIN_RST;
         else
            min_clamp = minutes;
      end
   endfunction

   // strictly above half, no bits lost in the doubling
   function above_half_of;
      input [`HLRT_VAL_W-1:0] volt;
      input [`HLRT_VAL_W-1:0] nom;
      begin
         above_half_of = ({volt, 1'b0} > {1'b0, nom});
      end
   endfunction

   assign evt_entry = {timestamp_in, evt_code_in};
   assign chg_entry = {chg_id_in, timestamp_in, chg_old_in, chg_new_in};

   // event log
   hlrt_log #(
      .W     (EVT_W),
      .DEPTH (EVT_DEPTH),
      .PW    (EVT_PW)
   ) u_evt_log (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .wr_in        (evt_valid_in),
      .data_in      (evt_entry),
      .clear_in     (1'b0),
      .rd_idx_in    (evt_rd_idx_in),
      .rd_data_out  (evt_rd_data_out),
      .rd_valid_out (evt_rd_valid_out),
      .count_out    (evt_count_out)
   );

   // change log
   hlrt_log #(
      .W     (CHG_W),
      .DEPTH (CHG_DEPTH),
      .PW    (CHG_PW)
   ) u_chg_log (
      .mclk_in      (mclk_in),
      .arst_n_in    (arst_n_in),
      .wr_in        (chg_valid_in),
      .data_in      (chg_entry),
      .clear_in     (chg_clear_in),
      .rd_idx_in    (chg_rd_idx_in),
      .rd_data_out  (chg_rd_data_out),
      .rd_valid_out (chg_rd_valid_out),
      .count_out    (chg_count_out)
   );

   // one-minute time base
   always @* begin
      if ({32'h0, div_reg} >= MIN_CYCLES - 64'd1) begin
         div_next  = 32'h0;
         tick_next = 1'b1;
      end else begin
         div_next  = div_reg + 32'h1;
         tick_next = 1'b0;
      end
   end

   // run qualification and counter arithmetic
   always @* begin
      above_half    = above_half_of(emerg_volt_in, emerg_nom_in);
      count_ok      = src_is_emerg_in & rt_enable_in & above_half;
      hours_next    = rt_hours_out;
      minutes_next  = rt_minutes_out;
      save_cnt_next = save_cnt_reg;
      save_next     = 1'b0;
      if (rt_reset_in) begin
         hours_next    = `HLRT_HOURS_RST;
         minutes_next  = `HLRT_MIN_RST;
         save_cnt_next = 4'h0;
         save_next     = 1'b1;
      end else if (nv_load_in) begin
         hours_next    = nv_load_hours_in;
         minutes_next  = min_clamp(nv_load_minutes_in);
         save_cnt_next = 4'h0;
      end else if (min_tick_out && count_ok) begin
         {hours_next, minutes_next} = rt_advance(rt_hours_out, rt_minutes_out);
         if (save_cnt_reg == `HLRT_NV_SAVE_MIN - 4'd1) begin
            save_cnt_next = 4'h0;
            save_next     = 1'b1;
         end else begin
            save_cnt_next = save_cnt_reg + 4'h1;
         end
      end
   end

   // time base runs from reset release whatever the run state
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_reg      <= 32'h0;
         min_tick_out <= 1'b0;
      end else begin
         div_reg      <= div_next;
         min_tick_out <= tick_next;
      end
   end

   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rt_hours_out   <= `HLRT_HOURS_RST;
         rt_minutes_out <= `HLRT_MIN_RST;
         rt_running_out <= 1'b0;
         save_cnt_reg   <= 4'h0;
         nv_save_out    <= 1'b0;
         nv_hours_out   <= `HLRT_HOURS_RST;
         nv_minutes_out <= `HLRT_MIN_RST;
      end else begin
         rt_hours_out   <= hours_next;
         rt_minutes_out <= minutes_next;
         rt_running_out <= count_ok;
         save_cnt_reg   <= save_cnt_next;
         nv_save_out    <= save_next;
         if (save_next) begin
            // snapshot handed to the non-volatile store
            nv_hours_out   <= hours_next;
            nv_minutes_out <= minutes_next;
         end
      end
   end
endmodule // hlrt_top

// ===== shared/hlrt_defs.vh
// constants for the history logs and run timer block
`ifndef HLRT_DEFS_VH
`define HLRT_DEFS_VH
`define HLRT_EVT_DEPTH      100
`define HLRT_EVT_PW         7
`define HLRT_CHG_DEPTH      50
`define HLRT_CHG_PW         6
`define HLRT_TS_W           32
`define HLRT_CODE_W         8
`define HLRT_VAL_W          16
`define HLRT_CLK_HZ         64'd40000000
`define HLRT_MINUTE_S       64'd60
`define HLRT_MINUTE_CYCLES  (`HLRT_MINUTE_S * `HLRT_CLK_HZ)
`define HLRT_MIN_LAST       6'd59
`define HLRT_MIN_RST        6'h00
`define HLRT_HOURS_LAST     16'hffff
`define HLRT_HOURS_RST      16'h0000
`define HLRT_NV_SAVE_MIN    4'd15
`endif

// ===== hw/hlrt_log.v
// circular history log, newest entry read at index 0
`timescale 1ns/1ps
module hlrt_log #(
   parameter W     = 40,
   parameter DEPTH = 100,
   parameter PW    = 7
) (
   input  wire          mclk_in,
   input  wire          arst_n_in,
   input  wire          wr_in,
   input  wire [W-1:0]  data_in,
   input  wire          clear_in,
   input  wire [PW-1:0] rd_idx_in,
   output reg  [W-1:0]  rd_data_out,
   output reg           rd_valid_out,
   output reg  [PW-1:0] count_out
);
   localparam integer  DEPTH_I = DEPTH;
   localparam [PW-1:0] LAST    = DEPTH_I[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};
   localparam [PW:0]   DEPTHX  = DEPTH_I[PW:0];

   reg [W-1:0]  mem_reg [0:DEPTH-1];
   reg [PW-1:0] wr_ptr_reg;
   reg [PW:0]   pos_raw;
   reg [PW:0]   pos;
   reg          hit;

   // index 0 sits just behind the write pointer
   always @* begin
      pos_raw = {1'b0, wr_ptr_reg} + DEPTHX - {{PW{1'b0}}, 1'b1} - {1'b0, rd_idx_in};
      pos     = (pos_raw >= DEPTHX) ? (pos_raw - DEPTHX) : pos_raw;
      hit     = (rd_idx_in < count_out);
   end

   always @(posedge mclk_in) begin
      if (wr_in) begin
         if (clear_in)
            mem_reg[0] <= data_in;
         else
            mem_reg[wr_ptr_reg] <= data_in;
      end
   end

   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr_reg   <= {PW{1'b0}};
         count_out    <= {PW{1'b0}};
         rd_data_out  <= {W{1'b0}};
         rd_valid_out <= 1'b0;
      end else begin
         if (clear_in) begin
            // clear empties the log; a write in the same cycle lands as entry 0
            wr_ptr_reg <= wr_in ? {{(PW-1){1'b0}}, 1'b1} : {PW{1'b0}};
            count_out  <= wr_in ? {{(PW-1){1'b0}}, 1'b1} : {PW{1'b0}};
         end else if (wr_in) begin
            // full log overwrites its oldest slot
            wr_ptr_reg <= (wr_ptr_reg == LAST) ? {PW{1'b0}} : wr_ptr_reg + {{(PW-1){1'b0}}, 1'b1};
            if (count_out != LAST + {{(PW-1){1'b0}}, 1'b1})
               count_out <= count_out + {{(PW-1){1'b0}}, 1'b1};
         end
         rd_valid_out <= hit;
         rd_data_out  <= hit ? mem_reg[pos[PW-1:0]] : {W{1'b0}};
      end
   end
endmodule // hlrt_log

// ===== verif/hlrt_top_asserts.sv
// run timer and log count checker for hlrt_top
`timescale 1ns/1ps
module hlrt_chk #(parameter EVT_DEPTH = 100, parameter CHG_DEPTH = 50) (
   input wire        mclk_in,
   input wire        arst_n_in,
   input wire        src_is_emerg_in,
   input wire        rt_enable_in,
   input wire [15:0] emerg_volt_in,
   input wire [15:0] emerg_nom_in,
   input wire        rt_reset_in,
   input wire        nv_load_in,
   input wire        chg_valid_in,
   input wire        chg_clear_in,
   input wire [5:0]  chg_count_out,
   input wire [6:0]  evt_count_out,
   input wire [15:0] rt_hours_out,
   input wire [5:0]  rt_minutes_out,
   input wire        min_tick_out,
   input wire        nv_save_out,
   input wire        rt_running_out,
   input wire [15:0] nv_hours_out,
   input wire [5:0]  nv_minutes_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   wire qual = src_is_emerg_in && rt_enable_in && {emerg_volt_in, 1'b0} > {1'b0, emerg_nom_in};
   wire idle = !rt_reset_in && !nv_load_in;
   sequence s_count; min_tick_out && qual && idle; endsequence
   sequence s_skip; min_tick_out && !qual && idle; endsequence
   chk_skip_hold: assert property (s_skip |=> $stable({rt_hours_out, rt_minutes_out}))
      else $error("run time moved while not qualified");
   chk_no_tick: assert property (!min_tick_out && idle |=> $stable(rt_minutes_out))
      else $error("run time moved between minute ticks");
   chk_minute_step: assert property (s_count |=> rt_minutes_out ==
      (($past(rt_minutes_out) == 6'h3b) ? 6'h00 : $past(rt_minutes_out) + 6'h01))
      else $error("minutes did not step");
   chk_hour_carry: assert property (s_count ##0 rt_minutes_out == 6'h3b
      |=> rt_hours_out == $past(rt_hours_out) + 16'h0001) else $error("hours did not carry");
   chk_user_zero: assert property (rt_reset_in |=> rt_hours_out == 16'h0000
      && rt_minutes_out == 6'h00 && nv_save_out) else $error("run time not zeroed");
   chk_min_range: assert property (rt_minutes_out <= 6'h3b)
      else $error("minutes out of range");
   chk_evt_cap: assert property (evt_count_out <= EVT_DEPTH)
      else $error("event count above depth");
   chk_chg_cap: assert property (chg_count_out <= CHG_DEPTH)
      else $error("change count above depth");
   chk_chg_clear: assert property (chg_clear_in && !chg_valid_in |=> chg_count_out == 6'h00)
      else $error("change log not emptied");
   chk_tick_pulse: assert property (min_tick_out |=> !min_tick_out)
      else $error("minute tick longer than one cycle");
   chk_run_flag: assert property (qual |=> rt_running_out)
      else $error("running flag missed a qualified cycle");
   chk_run_idle: assert property (!qual |=> !rt_running_out)
      else $error("running flag set while not qualified");
   chk_nv_snap: assert property (nv_save_out |-> {nv_hours_out, nv_minutes_out} ==
      {rt_hours_out, rt_minutes_out}) else $error("saved run time differs from counter");
endmodule // hlrt_chk
bind hlrt_top hlrt_chk #(.EVT_DEPTH(EVT_DEPTH), .CHG_DEPTH(CHG_DEPTH)) i_chk (.*);

// ===== verif/hlrt_far.sv
// far side: date and time word and emergency voltage source
`timescale 1ns/1ps
module hlrt_far #(parameter [15:0] NOM = 16'h00f0) (
   input  wire        mclk_in,
   input  wire        arst_n_in,
   input  wire        hi_in,
   output reg  [31:0] ts_out,
   output wire [15:0] volt_out,
   output wire [15:0] nom_out
);
   assign nom_out = NOM;
   // low sits exactly at half of nominal
   assign volt_out = (NOM >> 1) + {15'h0000, hi_in};
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) ts_out <= 32'h00000000;
      else ts_out <= ts_out + 32'h00000001;
   end
endmodule // hlrt_far

// ===== verif/hlrt_top_tb.sv
// self-checking bench of hlrt_top
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
   n_errors = n_errors + 1; $display("wrong value %s exp %h seen %h", n, e, g); end end
module hlrt_top_tb;
   reg mclk_in = 1'b0, arst_n_in = 1'b0, evt_valid_in = 1'b0, chg_valid_in = 1'b0, hi = 1'b0;
   reg chg_clear_in = 1'b0, src_is_emerg_in = 1'b0, rt_enable_in = 1'b0, rt_reset_in = 1'b0;
   reg nv_load_in = 1'b0;
   reg [7:0] evt_code_in = 8'h00, chg_id_in = 8'h00;
   reg [15:0] chg_old_in = 16'h0000, chg_new_in = 16'h0000, nv_load_hours_in = 16'h0000;
   reg [5:0] chg_rd_idx_in = 6'h00, nv_load_minutes_in = 6'h00;
   reg [6:0] evt_rd_idx_in = 7'h00;
   wire [31:0] timestamp_in;
   wire [15:0] emerg_volt_in, emerg_nom_in, rt_hours_out, nv_hours_out;
   wire [5:0] rt_minutes_out, nv_minutes_out, chg_count_out;
   wire [6:0] evt_count_out;
   wire [39:0] evt_rd_data_out;
   wire [71:0] chg_rd_data_out;
   wire evt_rd_valid_out, chg_rd_valid_out, rt_running_out, min_tick_out, nv_save_out;
   integer n_errors = 0, compares = 0, seed = 32'hc8a0e810, i, sc = 0, n_save = 0, x_save = 0;
   reg [21:0] x_rt = 22'h000000;
   reg [21:0] x_nv = 22'h000000;
   reg [63:0] rnd = 64'h0;
   integer gap = 0;
   localparam [63:0] TICK = 64'h8;
   reg [39:0] eq[$];
   reg [71:0] cq[$];
   hlrt_top #(.MIN_CYCLES(TICK)) i_dut (.*);
   hlrt_far i_far (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .hi_in(hi), .ts_out(timestamp_in),
      .volt_out(emerg_volt_in), .nom_out(emerg_nom_in));
   always #12.5 mclk_in = ~mclk_in;
   function [21:0] nxt(input [21:0] v);
      nxt = (v[5:0] == 6'h3b) ? {v[21:6] + 16'h0001, 6'h00} : v + 22'h000001;
   endfunction
   always @(posedge mclk_in) begin
      if (evt_valid_in) eq.push_front({timestamp_in, evt_code_in});
      if (eq.size() > 100) eq.pop_back();
      if (chg_clear_in) cq.delete();
      if (chg_valid_in) cq.push_front({chg_id_in, timestamp_in, chg_old_in, chg_new_in});
      if (cq.size() > 50) cq.pop_back();
      if (nv_save_out) n_save = n_save + 1;
      if (min_tick_out) begin
         `CHK("tick gap", TICK, gap)
         gap = 1;
      end else if (arst_n_in) gap = gap + 1;
      if (rt_reset_in) begin
         x_rt = 22'h000000;
         x_nv = 22'h000000;
         sc = 0;
         x_save = x_save + 1;
      end else if (nv_load_in) begin
         x_rt = {nv_load_hours_in, (nv_load_minutes_in > 6'h3b) ? 6'h00 : nv_load_minutes_in};
         sc = 0;
      end else if (min_tick_out && src_is_emerg_in && rt_enable_in
                   && {emerg_volt_in, 1'b0} > {1'b0, emerg_nom_in}) begin
         x_rt = nxt(x_rt);
         sc = (sc == 14) ? 0 : sc + 1;
         if (sc == 0) begin
            x_save = x_save + 1;
            x_nv = x_rt;
         end
      end
   end
   task conclude;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wr(input integer n, input cl);
      for (i = 0; i < n; i = i + 1) begin
         @(posedge mclk_in);
         evt_valid_in <= 1'b1;
         chg_valid_in <= 1'b1;
         chg_clear_in <= cl && i == n - 1;
         rnd = {$random(seed), $random(seed)};
         evt_code_in <= rnd[7:0];
         {chg_id_in, chg_old_in, chg_new_in} <= rnd[47:8];
      end
      @(posedge mclk_in);
      {evt_valid_in, chg_valid_in, chg_clear_in} <= 3'h0;
      #1;
   endtask
   task rd(input [6:0] k);
      @(posedge mclk_in);
      evt_rd_idx_in <= k;
      chg_rd_idx_in <= k[5:0];
      @(posedge mclk_in);
      #1;
      `CHK("evt data", (k < eq.size()) ? eq[k] : 40'h0, evt_rd_data_out)
      `CHK("evt valid", k < eq.size(), evt_rd_valid_out)
      `CHK("chg data", (k[5:0] < cq.size()) ? cq[k[5:0]] : 72'h0, chg_rd_data_out)
      `CHK("chg valid", k[5:0] < cq.size(), chg_rd_valid_out)
   endtask
   initial begin
      #1000000;
      n_errors = n_errors + 1;
      conclude;
   end
   initial begin
      repeat (8) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      wr(105, 1'b0);
      `CHK("evt count", 7'h64, evt_count_out)
      `CHK("chg count", 6'h32, chg_count_out)
      for (i = 0; i < 102; i = i + 1) rd(i[6:0]);
      wr(3, 1'b1);
      `CHK("chg count", 6'h01, chg_count_out)
      rd(7'h00);
      @(posedge mclk_in);
      chg_clear_in <= 1'b1;
      @(posedge mclk_in);
      chg_clear_in <= 1'b0;
      rd(7'h00);
      `CHK("chg count", 6'h00, chg_count_out)
      @(posedge mclk_in);
      {src_is_emerg_in, rt_enable_in, hi} <= 3'h7;
      repeat (160) @(posedge mclk_in);
      repeat (400) @(posedge mclk_in) begin
         rnd[31:0] = $random(seed);
         {src_is_emerg_in, rt_enable_in, hi} <= rnd[2:0];
      end
      {nv_load_in, nv_load_hours_in, nv_load_minutes_in} <= {1'b1, 16'hffff, 6'h3b};
      @(posedge mclk_in);
      {nv_load_in, src_is_emerg_in, rt_enable_in, hi} <= 4'h7;
      repeat (130) @(posedge mclk_in);
      #1;
      `CHK("run time", x_rt, {rt_hours_out, rt_minutes_out})
      `CHK("nv snapshot", x_nv, {nv_hours_out, nv_minutes_out})
      @(posedge mclk_in);
      rt_reset_in <= 1'b1;
      rt_enable_in <= 1'b0;
      @(posedge mclk_in);
      rt_reset_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      #1;
      `CHK("run time", 22'h000000, {rt_hours_out, rt_minutes_out})
      `CHK("nv snapshot", 22'h000000, {nv_hours_out, nv_minutes_out})
      `CHK("save count", x_save, n_save)
      @(posedge mclk_in);
      {nv_load_in, nv_load_hours_in, nv_load_minutes_in} <= {1'b1, 16'h1234, 6'h3c};
      @(posedge mclk_in);
      nv_load_in <= 1'b0;
      #1;
      `CHK("restored time", {16'h1234, 6'h00}, {rt_hours_out, rt_minutes_out})
      `CHK("restored model", x_rt, {rt_hours_out, rt_minutes_out})
      conclude;
   end
endmodule // hlrt_top_tb
